/* File: logic/asbla_controller.sv */
`timescale 1ns/1ps
module asbla_controller #(
   parameter int unsigned power_up_count = asbla_pkg::power_up_cycles,
   parameter int unsigned read_count = asbla_pkg::read_cycles
) (
   // Clock, reset and enable.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_enable,
   // User request side.
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [asbla_pkg::addr_width-1:0] req_addr,
   input wire logic [asbla_pkg::data_width-1:0] req_wdata,
   input wire logic [1:0] req_lane_n,
   output logic rsp_valid,
   output logic [asbla_pkg::data_width-1:0] rsp_rdata,
   output logic power_ready,
   // Memory pins.
   output logic [asbla_pkg::addr_width-1:0] mem_addr,
   output logic chip_select_n,
   output logic output_gate_n,
   output logic write_strobe_n,
   output logic low_byte_lane_n,
   output logic high_byte_lane_n,
   input wire logic [asbla_pkg::data_width-1:0] mem_data_in,
   output logic [asbla_pkg::data_width-1:0] mem_data_out,
   output logic mem_data_oe
);
   localparam int unsigned cw = asbla_pkg::count_width;
   logic sync_a;
   logic rst_n;
   asbla_pkg::asbla_state_t state;
   asbla_pkg::asbla_state_t next_state;
   logic load;
   logic [cw-1:0] load_value;
   logic done;
   logic accept;

   // The reset release is synchronised so all state leaves reset on the same edge.
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync_a <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         sync_a <= 1'b1;
         rst_n <= sync_a;
      end
   end

   asbla_timer #(.width(cw)) timer (
      .clock(clock),
      .rst_n(rst_n),
      .clock_enable(clock_enable),
      .load(load),
      .load_value(load_value),
      .done(done)
   );

   assign accept = (state == asbla_pkg::asbla_idle) && req_valid;
   assign req_ready = (state == asbla_pkg::asbla_idle);

   always_comb
   begin
      next_state = state;
      load = 1'b0;
      load_value = '0;
      unique case (state)
         asbla_pkg::asbla_wait_t_power:
            if (power_ready)
               next_state = asbla_pkg::asbla_idle;
         asbla_pkg::asbla_idle:
            if (req_valid)
            begin
               load = 1'b1;
               if (req_write)
               begin
                  // Output gate stays low, so the bus is left to float first.
                  next_state = asbla_pkg::asbla_write_float;
                  load_value = cw'(asbla_pkg::float_cycles - 1);
               end
               else
               begin
                  next_state = asbla_pkg::asbla_read;
                  load_value = cw'(read_count - 1);
               end
            end
         asbla_pkg::asbla_read:
            if (done)
            begin
               next_state = asbla_pkg::asbla_recover;
               load = 1'b1;
               load_value = cw'(asbla_pkg::turn_cycles - 1);
            end
         asbla_pkg::asbla_write_float:
            if (done)
            begin
               next_state = asbla_pkg::asbla_write_data;
               load = 1'b1;
               load_value = cw'(asbla_pkg::strobe_cycles - 1);
            end
         asbla_pkg::asbla_write_data:
            if (done)
            begin
               next_state = asbla_pkg::asbla_recover;
               load = 1'b1;
               load_value = cw'(asbla_pkg::turn_cycles - 1);
            end
         asbla_pkg::asbla_recover:
            if (done)
               next_state = asbla_pkg::asbla_idle;
         default:
            next_state = asbla_pkg::asbla_idle;
      endcase
      if (state == asbla_pkg::asbla_wait_t_power && !done)
         load_value = '0;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         state <= asbla_pkg::asbla_wait_t_power;
      else if (clock_enable)
         state <= next_state;
   end

   // The power-up wait uses a separate counter since it runs before any timer load.
   logic [cw+1:0] power_count;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         power_count <= '0;
      else if (clock_enable && power_count != (cw+2)'(power_up_count))
         power_count <= power_count + 1'b1;
   end
   assign power_ready = (power_count == (cw+2)'(power_up_count));

   // Pin and latch registers; select and lanes are held across the whole access, the strobe until its data phase ends.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_addr <= '0;
         chip_select_n <= 1'b1;
         output_gate_n <= 1'b1;
         write_strobe_n <= 1'b1;
         low_byte_lane_n <= 1'b1;
         high_byte_lane_n <= 1'b1;
         mem_data_out <= '0;
         mem_data_oe <= 1'b0;
      end
      else if (clock_enable)
      begin
         if (accept && power_ready)
         begin
            // Address, select, lanes, gate and strobe all change together on this one edge.
            mem_addr <= req_addr;
            chip_select_n <= 1'b0;
            low_byte_lane_n <= req_lane_n[0];
            high_byte_lane_n <= req_lane_n[1];
            output_gate_n <= 1'b0;
            // A write with both lanes off would store nothing, so strobe and drive are skipped.
            write_strobe_n <= !req_write || (&req_lane_n);
            mem_data_out <= req_wdata;
         end
         else if (state == asbla_pkg::asbla_write_float && done)
            mem_data_oe <= !write_strobe_n;
         else if ((state == asbla_pkg::asbla_write_data || state == asbla_pkg::asbla_read)
            && done)
         begin
            // Strobe, output gate and data drive end together; select and lanes follow a cycle later.
            write_strobe_n <= 1'b1;
            output_gate_n <= 1'b1;
            mem_data_oe <= 1'b0;
         end
         else if (state == asbla_pkg::asbla_recover)
         begin
            chip_select_n <= 1'b1;
            low_byte_lane_n <= 1'b1;
            high_byte_lane_n <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end
      else if (clock_enable)
      begin
         rsp_valid <= 1'b0;
         if (state == asbla_pkg::asbla_read && done)
         begin
            rsp_valid <= 1'b1;
            // Lanes not enabled float, so they read back as zero.
            rsp_rdata[asbla_pkg::lane_width-1:0] <= low_byte_lane_n ? '0
               : mem_data_in[asbla_pkg::lane_width-1:0];
            rsp_rdata[asbla_pkg::data_width-1:asbla_pkg::lane_width] <= high_byte_lane_n ? '0
               : mem_data_in[asbla_pkg::data_width-1:asbla_pkg::lane_width];
         end
      end
   end
endmodule

/* File: logic/asbla_timer.sv */
`timescale 1ns/1ps
module asbla_timer #(
   parameter int unsigned width = 14
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clock_enable,
   // Control.
   input wire logic load,
   input wire logic [width-1:0] load_value,
   output logic done
);
   logic [width-1:0] count;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         count <= '0;
      else if (clock_enable)
      begin
         if (load)
            count <= load_value;
         else if (count != '0)
            count <= count - 1'b1;
      end
   end

   // Done must not look at load, since the caller decides load from done.
   assign done = (count == '0);
endmodule

/* File: pkg/asbla_pkg.sv */
package asbla_pkg;
   localparam int unsigned clock_period_ps = 10000;
   localparam int unsigned power_up_us = 100;
   localparam int unsigned power_up_cycles = (power_up_us * 1000000 + clock_period_ps - 1)
      / clock_period_ps;
   localparam int unsigned read_access_ns = 10;
   localparam int unsigned strobe_to_float_delay_ns = 5;
   localparam int unsigned data_setup_before_strobe_end_ns = 5;
   localparam int unsigned strobe_width_ns = 7;
   localparam int unsigned float_to_turn_ns = 5;
   localparam int unsigned read_cycles = (read_access_ns * 1000 + clock_period_ps - 1)
      / clock_period_ps + 1;
   localparam int unsigned float_cycles = (strobe_to_float_delay_ns * 1000 + clock_period_ps - 1)
      / clock_period_ps;
   localparam int unsigned setup_cycles =
      (data_setup_before_strobe_end_ns * 1000 + clock_period_ps - 1) / clock_period_ps;
   localparam int unsigned strobe_cycles = (strobe_width_ns * 1000 + clock_period_ps - 1)
      / clock_period_ps;
   localparam int unsigned turn_cycles = (float_to_turn_ns * 1000 + clock_period_ps - 1)
      / clock_period_ps;
   localparam int unsigned addr_width = 18;
   localparam int unsigned data_width = 16;
   localparam int unsigned lane_width = 8;
   localparam int unsigned count_width = 14;
   typedef enum logic [2:0]
   {
      asbla_wait_t_power = 3'b000,
      asbla_idle = 3'b001,
      asbla_read = 3'b011,
      asbla_write_float = 3'b010,
      asbla_write_data = 3'b110,
      asbla_recover = 3'b111
   } asbla_state_t;
endpackage

/* File: verification/asbla_controller_chk.sv */
`timescale 1ns/1ps
module asbla_controller_chk #(
   parameter int unsigned power_up_count = 4,
   parameter int unsigned read_count = 2
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Observed ports.
   input wire logic power_ready,
   input wire logic rsp_valid,
   input wire logic chip_select_n,
   input wire logic output_gate_n,
   input wire logic write_strobe_n,
   input wire logic low_byte_lane_n,
   input wire logic high_byte_lane_n,
   input wire logic mem_data_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   quiet_powerup_a: assert property (!power_ready |-> chip_select_n && !mem_data_oe)
      else $error("access before power up");
   write_select_a: assert property (!write_strobe_n |->
      !chip_select_n && !(low_byte_lane_n && high_byte_lane_n))
      else $error("bad write controls");
   drive_in_write_a: assert property (mem_data_oe |-> !write_strobe_n)
      else $error("data driven outside write");
   late_drive_a: assert property ($rose(mem_data_oe) |-> !$past(write_strobe_n))
      else $error("data driven before float delay");
   strobe_width_a: assert property ($fell(write_strobe_n) |-> ##1 !write_strobe_n)
      else $error("write strobe too short");
   data_setup_a: assert property ($rose(write_strobe_n) |-> $past(mem_data_oe))
      else $error("write data not set up");
   bus_release_a: assert property ($rose(write_strobe_n) |-> !mem_data_oe)
      else $error("data held after write");
   cover property ($rose(mem_data_oe) && !output_gate_n);
   cover property (rsp_valid);
   cover property ($rose(power_ready));
endmodule
bind asbla_controller asbla_controller_chk #(.power_up_count(power_up_count),
   .read_count(read_count)) i_asbla_controller_chk (.clock(clock), .reset_n(reset_n),
   .power_ready(power_ready), .rsp_valid(rsp_valid), .chip_select_n(chip_select_n),
   .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
   .low_byte_lane_n(low_byte_lane_n), .high_byte_lane_n(high_byte_lane_n),
   .mem_data_oe(mem_data_oe));

/* File: verification/asbla_sram_model.sv */
`timescale 1ns/1ps
module asbla_sram_model (
   // Memory pins.
   input wire logic [17:0] mem_addr,
   input wire logic chip_select_n,
   input wire logic output_gate_n,
   input wire logic write_strobe_n,
   input wire logic low_byte_lane_n,
   input wire logic high_byte_lane_n,
   input wire logic [15:0] mem_data_out,
   input wire logic mem_data_oe,
   output logic [15:0] mem_data_in,
   output logic clash
);
   logic [15:0] store [0:262143];
   logic [1:0] lane;
   logic [1:0] drive;
   logic [15:0] word;
   initial
   begin
      for (int i = 0; i < 262144; i++)
         store[i] = 16'h0000;
   end
   assign lane = {~high_byte_lane_n, ~low_byte_lane_n};
   assign word = store[mem_addr];
   // Floating is modelled with zero delay, so it always precedes any turn-on.
   assign drive = (!chip_select_n && !output_gate_n && write_strobe_n) ? lane : 2'b00;
   // A floating lane shows the inverse, never a value the controller could mistake.
   assign mem_data_in = {drive[1] ? word[15:8] : ~word[15:8], drive[0] ? word[7:0] : ~word[7:0]};
   assign clash = (|drive) && mem_data_oe;
   always @*
   begin
      if (!chip_select_n && !write_strobe_n && lane[0])
         store[mem_addr][7:0] = mem_data_out[7:0];
      if (!chip_select_n && !write_strobe_n && lane[1])
         store[mem_addr][15:8] = mem_data_out[15:8];
   end
endmodule

/* File: verification/tb_asbla_controller.sv */
`timescale 1ns/1ps
module tb_asbla_controller;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic clock_enable = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [17:0] req_addr = 18'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0] req_lane_n = 2'b11;
   logic req_ready, rsp_valid, power_ready, cs_n, gate_n, strobe_n, lo_n, hi_n, oe, clash;
   logic [15:0] rsp_rdata, din, dout;
   logic [17:0] addr;
   logic [15:0] shadow [int];
   logic [31:0] rnd = 32'h00004088;
   int failures = 0;
   int samples_checked = 0;
   always #5 clock = ~clock;
   asbla_controller #(.power_up_count(4)) i_asbla_controller (.clock(clock),
      .reset_n(reset_n), .clock_enable(clock_enable), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_lane_n(req_lane_n), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .power_ready(power_ready), .mem_addr(addr),
      .chip_select_n(cs_n), .output_gate_n(gate_n), .write_strobe_n(strobe_n),
      .low_byte_lane_n(lo_n), .high_byte_lane_n(hi_n), .mem_data_in(din),
      .mem_data_out(dout), .mem_data_oe(oe));
   asbla_sram_model i_asbla_sram_model (.mem_addr(addr), .chip_select_n(cs_n),
      .output_gate_n(gate_n), .write_strobe_n(strobe_n), .low_byte_lane_n(lo_n),
      .high_byte_lane_n(hi_n), .mem_data_out(dout), .mem_data_oe(oe),
      .mem_data_in(din), .clash(clash));
   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check({15'h0000, got}, {15'h0000, exp});
   endtask
   function automatic logic [15:0] expect_rd(input logic [17:0] a, input logic [1:0] l);
      logic [15:0] v;
      v = shadow.exists(a) ? shadow[a] : 16'h0000;
      return v & {{8{!l[1]}}, {8{!l[0]}}};
   endfunction
   // Stalls the controller now and then by gating its clock enable.
   task automatic tick();
      @(negedge clock);
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      clock_enable = rnd[2:0] != 3'h0;
   endtask
   task automatic wait_high(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1 || clock_enable !== 1'b1)
      begin
         tick();
         n++;
         if (n > 300)
         begin
            failures++;
            final_report();
         end
      end
   endtask
   task automatic op(input logic w, input logic [17:0] a, input logic [15:0] d,
      input logic [1:0] l);
      // One edge passes first, so the request never drops and rises in one time step.
      tick();
      {req_write, req_addr, req_wdata, req_lane_n, req_valid} = {w, a, d, l, 1'b1};
      wait_high(req_ready);
      tick();
      req_valid = 1'b0;
      if (w)
         shadow[a] = expect_rd(a, ~l) | (d & {{8{!l[1]}}, {8{!l[0]}}});
      else
      begin
         wait_high(rsp_valid);
         check(rsp_rdata, expect_rd(a, l));
      end
   endtask
   always @(negedge clock)
      if (reset_n)
         check_bit(clash, 1'b0);
   initial
   begin
      repeat (20) @(negedge clock);
      reset_n = 1'b1;
      tick();
      check_bit(power_ready, 1'b0);
      for (int l = 0; l < 4; l++)
      begin
         op(1'b1, 18'h3ffff, 16'ha5c3 ^ l[15:0], l[1:0]);
         op(1'b0, 18'h3ffff, 16'h0000, 2'b00);
      end
      check_bit(power_ready, 1'b1);
      $display("corner test done");
      repeat (60)
      begin
         tick();
         op(rnd[0], rnd[9] ? 18'h3ffff - rnd[2:1] : {16'h0000, rnd[2:1]}, rnd[31:16],
            rnd[11:10]);
      end
      $display("random test done");
      final_report();
   end
endmodule
